//--- inc/irq_tb_pkg.sv
/*
 * Shared constants and carriers for the interrupt and time base unit: register
 * offsets, field positions, source numbering, priority order and event and request carriers.
 * Assumes a 32-bit classic Wishbone register bus with 8-bit registers in the low byte.
 */
package irq_tb_pkg;

   // Register byte offsets on the 32-bit bus.
   localparam logic [7:0] OFS_CTRL0 = 8'h00;
   localparam logic [7:0] OFS_CTRL1 = 8'h04;
   localparam logic [7:0] OFS_CTRL2 = 8'h08;
   localparam logic [7:0] OFS_EDGE = 8'h0C;
   localparam logic [7:0] OFS_PSC = 8'h10;
   localparam logic [7:0] OFS_TB0 = 8'h14;
   localparam logic [7:0] OFS_TB1 = 8'h18;
   localparam logic [7:0] OFS_CARD_EN = 8'h1C;
   localparam logic [7:0] OFS_STATUS = 8'h20;
   localparam int ADDR_LSB = 2;
   localparam int ADDR_W = 8;

   // Source numbering; a lower number wins when several requests are pending.
   localparam int NSRC = 9;
   localparam int SRC_CARD = 0;
   localparam int SRC_EP = 1;
   localparam int SRC_EXT0 = 2;
   localparam int SRC_EXT1 = 3;
   localparam int SRC_UART0 = 4;
   localparam int SRC_UART1 = 5;
   localparam int SRC_PRES = 6;
   localparam int SRC_TB0 = 7;
   localparam int SRC_TB1 = 8;

   // Placement of each source's enable and flag within the three control registers.
   localparam int SRC_REG [NSRC] = '{0, 0, 0, 1, 1, 1, 1, 2, 2};
   localparam int EN_BIT [NSRC] = '{1, 2, 3, 0, 1, 2, 3, 2, 3};
   localparam int FL_BIT [NSRC] = '{4, 5, 6, 4, 5, 6, 7, 6, 7};
   localparam int GIE_BIT = 0;

   // Time base control fields and period range.
   localparam int TB_RUN_BIT = 7;
   localparam int TB_CODE_W = 3;
   localparam int TB_CNT_W = 15;
   localparam logic [TB_CNT_W-1:0] TB_FULL_MASK = 15'h7FFF;
   localparam logic [2:0] TB_CODE_MAX = 3'h7;

   // Prescaler source field and the divide-by-four counter.
   localparam int PSC_W = 2;
   localparam logic [1:0] PSC_SYS = 2'h0;
   localparam logic [1:0] PSC_SYS_DIV4 = 2'h1;
   localparam logic [1:0] DIV4_LAST = 2'h3;

   // External pin edge selector codes, two bits per pin.
   localparam int NPIN = 2;
   localparam logic [1:0] EDGE_OFF = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   localparam int NCARD_EV = 6;
   localparam int VEC_W = 4;

   // Event pulses from peripherals on the system clock.
   typedef struct packed {
      logic [NCARD_EV-1:0] card;
      logic presence;
      logic endpoint;
      logic [1:0] uart;
   } irq_events_s;

   // Request to the processor core.
   typedef struct packed {
      logic req;
      logic [VEC_W-1:0] vector;
   } core_req_s;

endpackage : irq_tb_pkg

//--- core/interrupt_and_time_base_unit.sv
/*
 * Interrupt controller with two time bases for an 8-bit processor core.
 * Assumes event pulses on the system clock, asynchronous external pins,
 * a core that pulses its acknowledge against a standing request, and a
 * classic Wishbone master on the register bus.
 */
// Contract
// - Taking any request clears the global enable, so no nesting happens.
// - Requests arriving while blocked still set and hold their flags.
// - No request is offered or taken while the return stack is full.
// - Any flag becoming set raises wake; pre-set flags cause no wake.
// - A call needs global enable, source enable, stack not full, flag set.
// - Sources have their own vectors; shared multi-function vectors exist elsewhere.
// - Simultaneous pending requests resolve by fixed priority.
// - Any enabled card event sets the card event flag.
// - Writing any nonzero card event enable forces the card interrupt enable on.
// - Servicing the card event interrupt clears its flag.
// - Endpoint access sets the endpoint flag; servicing clears it.
// - External pins set flags on the chosen edge, or are disabled.
// - Edge code: 00 off, 01 rising, 10 falling, 11 both.
// - A pin interrupts only if enabled, selected for interrupt and an input.
// - Servicing an external interrupt clears its flag; pull-ups stay untouched.
// - Any serial port condition sets its flag; servicing clears it.
// - Card insertion or removal sets the presence flag; servicing clears it.
// - Each time base overflow sets its flag; servicing clears it.
// - Prescaler source: 00 system clock, 01 system clock over four, 1x sub-clock.
// - Time base zero runs only while its run bit 7 is one.
// - Period code 000 gives 2^8 prescaler clocks up to 111 giving 2^15.
// - Time base one has its own run bit 7 and period code alike.
// - Control register zero holds global enable at bit 0; bit 7 reads zero.
`timescale 1ns/1ns

module interrupt_and_time_base_unit (
   input wire logic clk,
   input wire logic rst,
   // Wishbone classic slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [irq_tb_pkg::ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Peripheral events and pins.
   input wire irq_tb_pkg::irq_events_s events,
   input wire logic [irq_tb_pkg::NPIN-1:0] ext_irq_pins,
   input wire logic [irq_tb_pkg::NPIN-1:0] ext_pin_func_sel,
   input wire logic [irq_tb_pkg::NPIN-1:0] ext_pin_dir_in,
   input wire logic sub_clock_tick,
   // Processor core side.
   input wire logic stack_full,
   input wire logic core_ack,
   output irq_tb_pkg::core_req_s core_req,
   output logic wake
);
   import irq_tb_pkg::*;

   // Register state.
   logic global_irq_enable_q;
   logic [NSRC-1:0] en_q;
   logic [NSRC-1:0] flag_q;
   logic [NSRC-1:0] flag_d;
   logic [2*NPIN-1:0] ext_edge_select_q;
   logic [PSC_W-1:0] prescaler_source_field_q;
   logic [NCARD_EV-1:0] card_ev_en_q;
   logic [NPIN-1:0] tb_run_q;
   logic [TB_CODE_W-1:0] tb_code_q [NPIN];

   // Bus and core output flops.
   logic ack_q;
   logic [31:0] dat_q;
   core_req_s req_q;
   logic wake_q;

   // Bus decode.
   wire access = wb_cyc_i && wb_stb_i;
   wire ack_d = access && !ack_q;
   wire wr_fire = access && wb_we_i && ack_q && wb_sel_i[0];
   wire [ADDR_W-1:0] reg_adr = {wb_adr_i[ADDR_W-1:ADDR_LSB], {ADDR_LSB{1'b0}}};
   wire [7:0] wdat = wb_dat_i[7:0];
   wire wr_ctrl0 = wr_fire && (reg_adr == OFS_CTRL0);
   wire wr_ctrl1 = wr_fire && (reg_adr == OFS_CTRL1);
   wire wr_ctrl2 = wr_fire && (reg_adr == OFS_CTRL2);
   wire wr_edge = wr_fire && (reg_adr == OFS_EDGE);
   wire wr_psc = wr_fire && (reg_adr == OFS_PSC);
   wire wr_card_en = wr_fire && (reg_adr == OFS_CARD_EN);
   wire [NPIN-1:0] wr_tb;
   assign wr_tb[0] = wr_fire && (reg_adr == OFS_TB0);
   assign wr_tb[1] = wr_fire && (reg_adr == OFS_TB1);
   wire [2:0] wr_ctrl = {wr_ctrl2, wr_ctrl1, wr_ctrl0};

   // Service handshake: the core takes the standing request unless the stack is full.
   wire ack_fire = core_ack && req_q.req && !stack_full;
   wire [NSRC-1:0] ack_clr;
   wire [NSRC-1:0] pending = flag_q & en_q & {NSRC{global_irq_enable_q}};

   // Hardware set terms, one per source.
   logic [NSRC-1:0] hw_set;
   logic [NPIN-1:0] ext_hit;
   logic [NPIN-1:0] tb_ovf;

   // Card events count only when their own enable is on.
   assign hw_set[SRC_CARD] = |(events.card & card_ev_en_q);
   assign hw_set[SRC_EP] = events.endpoint;
   assign hw_set[SRC_EXT0] = ext_hit[0];
   assign hw_set[SRC_EXT1] = ext_hit[1];
   assign hw_set[SRC_UART0] = events.uart[0];
   assign hw_set[SRC_UART1] = events.uart[1];
   assign hw_set[SRC_PRES] = events.presence;
   assign hw_set[SRC_TB0] = tb_ovf[0];
   assign hw_set[SRC_TB1] = tb_ovf[1];

   // Lowest source number among pending requests wins.
   logic [VEC_W-1:0] win_vec;
   logic win_any;
   always_comb begin
      win_vec = '0;
      win_any = 1'b0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (pending[i]) begin
            win_vec = VEC_W'(i);
            win_any = 1'b1;
         end
      end
   end

   // Request offered to the core; withdrawn in the cycle it is taken.
   wire req_d = win_any && !stack_full && !ack_fire;

   // Per-source flag and enable update; a hardware set always beats any clear.
   genvar gs;
   generate
      for (gs = 0; gs < NSRC; gs++) begin : g_src
         wire sw_we = wr_ctrl[SRC_REG[gs]];
         assign ack_clr[gs] = ack_fire && (req_q.vector == VEC_W'(gs));
         assign flag_d[gs] = hw_set[gs] ||
                             (sw_we ? wdat[FL_BIT[gs]] : (flag_q[gs] && !ack_clr[gs]));

         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               flag_q[gs] <= 1'b0;
            end else begin
               flag_q[gs] <= flag_d[gs];
            end
         end

         // The card enable is also forced on by a nonzero card event enable write.
         wire force_en = (gs == SRC_CARD) && wr_card_en && (|wdat[NCARD_EV-1:0]);
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               en_q[gs] <= 1'b0;
            end else if (force_en) begin
               en_q[gs] <= 1'b1;
            end else if (sw_we) begin
               en_q[gs] <= wdat[EN_BIT[gs]];
            end
         end
      end
   endgenerate

   // Global enable: software write wins, otherwise taking a request clears it.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         global_irq_enable_q <= 1'b0;
      end else if (wr_ctrl0) begin
         global_irq_enable_q <= wdat[GIE_BIT];
      end else if (ack_fire) begin
         global_irq_enable_q <= 1'b0;
      end
   end

   // Plain configuration registers.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_edge_select_q <= '0;
         prescaler_source_field_q <= '0;
         card_ev_en_q <= '0;
      end else begin
         if (wr_edge) ext_edge_select_q <= wdat[2*NPIN-1:0];
         if (wr_psc) prescaler_source_field_q <= wdat[PSC_W-1:0];
         if (wr_card_en) card_ev_en_q <= wdat[NCARD_EV-1:0];
      end
   end

   // Prescaler clock enable: every cycle, every fourth cycle, or the sub-clock tick.
   logic [1:0] div4_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         div4_q <= '0;
      end else begin
         div4_q <= div4_q + 2'h1;
      end
   end
   wire psc_tick = (prescaler_source_field_q == PSC_SYS) ? 1'b1 :
                   (prescaler_source_field_q == PSC_SYS_DIV4) ? (div4_q == DIV4_LAST) :
                   sub_clock_tick;

   // External pins: synchronise, detect edges, qualify by enable, mux and direction.
   logic [NPIN-1:0] pin_s1_q;
   logic [NPIN-1:0] pin_s2_q;
   logic [NPIN-1:0] pin_prev_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_prev_q <= '0;
      end else begin
         pin_s1_q <= ext_irq_pins;
         pin_s2_q <= pin_s1_q;
         pin_prev_q <= pin_s2_q;
      end
   end

   // Pull-high selections live in the port logic and are left as they are here.
   genvar gp;
   generate
      for (gp = 0; gp < NPIN; gp++) begin : g_pin
         localparam int SRC_IDX = (gp == 0) ? SRC_EXT0 : SRC_EXT1;
         wire [1:0] sel = ext_edge_select_q[2*gp +: 2];
         wire rise = pin_s2_q[gp] && !pin_prev_q[gp];
         wire fall = !pin_s2_q[gp] && pin_prev_q[gp];
         wire edge_ok = ((sel == EDGE_RISE) && rise) || ((sel == EDGE_FALL) && fall) ||
                        ((sel == EDGE_BOTH) && (rise || fall));
         wire pin_live = en_q[SRC_IDX] && ext_pin_func_sel[gp] && ext_pin_dir_in[gp];
         assign ext_hit[gp] = edge_ok && pin_live && (sel != EDGE_OFF);
      end
   endgenerate

   // Time bases: a divider counts prescaler ticks up to a power-of-two period.
   logic [TB_CNT_W-1:0] tb_cnt_q [NPIN];
   genvar gt;
   generate
      for (gt = 0; gt < NPIN; gt++) begin : g_tb
         wire [TB_CNT_W-1:0] last = TB_FULL_MASK >> (TB_CODE_MAX - tb_code_q[gt]);
         wire step = tb_run_q[gt] && psc_tick;
         assign tb_ovf[gt] = step && (tb_cnt_q[gt] == last);

         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               tb_run_q[gt] <= 1'b0;
               tb_code_q[gt] <= '0;
            end else if (wr_tb[gt]) begin
               tb_run_q[gt] <= wdat[TB_RUN_BIT];
               tb_code_q[gt] <= wdat[TB_CODE_W-1:0];
            end
         end

         // A control write restarts the count so the next period is whole.
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               tb_cnt_q[gt] <= '0;
            end else if (wr_tb[gt] || tb_ovf[gt]) begin
               tb_cnt_q[gt] <= '0;
            end else if (step) begin
               tb_cnt_q[gt] <= tb_cnt_q[gt] + 15'h0001;
            end
         end
      end
   endgenerate

   // Control register images built from the per-source table.
   logic [7:0] rd_ctrl [3];
   always_comb begin
      for (int r = 0; r < 3; r++) begin
         rd_ctrl[r] = 8'h00;
      end
      for (int i = 0; i < NSRC; i++) begin
         rd_ctrl[SRC_REG[i]][EN_BIT[i]] = en_q[i];
         rd_ctrl[SRC_REG[i]][FL_BIT[i]] = flag_q[i];
      end
      rd_ctrl[0][GIE_BIT] = global_irq_enable_q;
   end

   // Read selection; unmapped addresses read zero.
   logic [7:0] rd_byte;
   always_comb begin
      unique case (reg_adr)
         OFS_CTRL0: rd_byte = rd_ctrl[0];
         OFS_CTRL1: rd_byte = rd_ctrl[1];
         OFS_CTRL2: rd_byte = rd_ctrl[2];
         OFS_EDGE: rd_byte = {4'h0, ext_edge_select_q};
         OFS_PSC: rd_byte = {6'h00, prescaler_source_field_q};
         OFS_TB0: rd_byte = {tb_run_q[0], 4'h0, tb_code_q[0]};
         OFS_TB1: rd_byte = {tb_run_q[1], 4'h0, tb_code_q[1]};
         OFS_CARD_EN: rd_byte = {2'h0, card_ev_en_q};
         OFS_STATUS: rd_byte = {req_q.req, stack_full, 2'h0, req_q.vector};
         default: rd_byte = 8'h00;
      endcase
   end

   // Bus answer: ack one cycle after the strobe, read data captured with it.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_q <= 1'b0;
         dat_q <= '0;
      end else begin
         ack_q <= ack_d;
         if (ack_d) dat_q <= {24'h000000, rd_byte};
      end
   end

   // Core request and wake flops; wake marks any flag newly set this cycle.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         req_q <= '0;
         wake_q <= 1'b0;
      end else begin
         req_q.req <= req_d;
         if (req_d) req_q.vector <= win_vec;
         wake_q <= |(flag_d & ~flag_q);
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign core_req = req_q;
   assign wake = wake_q;

endmodule : interrupt_and_time_base_unit

//--- bench/irq_unit_chk.sv
/* Concurrent checks on the ports of the interrupt and time base unit.
   Assumes a bind to the unit's top module on one clock with active high reset. */
`timescale 1ns/1ns
module irq_unit_chk (
   input wire logic clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic stack_full,
   input wire logic core_ack,
   input wire irq_tb_pkg::core_req_s core_req,
   input wire logic wake
);
   import irq_tb_pkg::*;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // A bus request, and a request taken by the core.
   sequence s_bus_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_take;
      core_ack && core_req.req && !stack_full;
   endsequence

   // Properties on the bus answer and on the core request.
   property p_ack_next;
      s_bus_req |=> wb_ack_o;
   endproperty
   property p_ack_once;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   property p_ack_cause;
      wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
   endproperty
   property p_dat_high;
      wb_ack_o |-> wb_dat_o[31:8] == 24'h0;
   endproperty
   property p_take_drop;
      s_take |=> !core_req.req;
   endproperty
   property p_full_block;
      stack_full |=> !core_req.req;
   endproperty
   property p_vec_range;
      core_req.req |-> core_req.vector < 4'h9;
   endproperty
   property p_reset_quiet;
      $fell(rst) |-> !core_req.req && !wake && !wb_ack_o;
   endproperty

   a_ack_next: assert property (p_ack_next)
      else $error("bus answer missing");
   a_ack_once: assert property (p_ack_once)
      else $error("bus answer too long");
   a_ack_cause: assert property (p_ack_cause)
      else $error("bus answer without request");
   a_dat_high: assert property (p_dat_high)
      else $error("read data upper bits set");
   a_take_drop: assert property (p_take_drop)
      else $error("request stands after take");
   a_full_block: assert property (p_full_block)
      else $error("request while stack full");
   a_vec_range: assert property (p_vec_range)
      else $error("vector out of range");
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs busy after reset");
   c_take: cover property (s_take);
endmodule : irq_unit_chk

//--- bench/core_model.sv
/* Behavioural processor core that takes vectored requests.
   Assumes a registered standing request and a stack full level from the bench. */
`timescale 1ns/1ns
module core_model (
   input wire logic clk,
   input wire logic rst,
   input wire irq_tb_pkg::core_req_s core_req,
   input wire logic stack_full,
   input wire logic hold,
   input wire logic slow,
   output logic core_ack
);
   import irq_tb_pkg::*;
   logic [1:0] wait_q;

   // Pulses acknowledge once per request, at once or after a pause.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         core_ack <= 1'b0;
         wait_q <= 2'h0;
      end else if (core_ack || !core_req.req || stack_full || hold) begin
         core_ack <= 1'b0;
         wait_q <= 2'h0;
      end else if (slow && wait_q != 2'h3) begin
         wait_q <= wait_q + 2'h1;
      end else begin
         core_ack <= 1'b1;
      end
   end
endmodule : core_model

//--- bench/testbench.sv
/* Self-checking bench for the interrupt and time base unit.
   Assumes the unit, its package, the core model and the checker. */
`timescale 1ns/1ns
module testbench;
   import irq_tb_pkg::*;
   logic clk, rst, cyc, stb, we, ack, wake, cack, full, hold, slow, stick;
   logic [7:0] adr, rd, a, e;
   logic [31:0] wdat, rdat, seed;
   logic [1:0] pins, fsel, cd;
   logic [3:0] tvec;
   irq_events_s ev;
   core_req_s creq;
   int fail_count, checks, cycles, taken, wakes, n, t, w, p;
   logic [1:0] pt [5] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
   int ct [5] = '{0, 1, 0, 0, 0};
   logic [7:0] pre [5] = '{8'h00, 8'h00, 8'h40, 8'h00, 8'h00};

   interrupt_and_time_base_unit interrupt_and_time_base_unit_i (.clk(clk), .rst(rst),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .events(ev), .ext_irq_pins(pins),
      .ext_pin_func_sel(fsel), .ext_pin_dir_in(2'h3), .sub_clock_tick(stick),
      .stack_full(full), .core_ack(cack), .core_req(creq), .wake(wake));
   core_model core_model_i (.clk(clk), .rst(rst), .core_req(creq), .stack_full(full),
      .hold(hold), .slow(slow), .core_ack(cack));

   // Clock, and a monitor of takes, wake pulses, sub-clock ticks and the time limit.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      stick <= (cycles % 8 == 7);
      wakes <= wakes + int'(wake === 1'b1);
      if (cack && creq.req && !full) begin
         taken <= taken + 1;
         tvec <= creq.vector;
      end
      if (cycles == 20000) begin
         fail_count++;
         summarize();
      end
   end

   function logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   function int period(input logic [1:0] ps, input int c);
      return (1 << (8 + c)) * ((ps == 2'h0) ? 1 : (ps == 2'h1) ? 4 : 8);
   endfunction : period
   function logic hit(input logic [1:0] c, input logic r, input logic f);
      return f & (r ? c[0] : c[1]);
   endfunction : hit

   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check
   task bus(input logic [7:0] ad, input logic wr, input logic [7:0] d);
      int k;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= wr;
      adr <= ad;
      wdat <= {24'h0, d};
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1);
      rd = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus
   task rdchk(input logic [7:0] ad, input logic [7:0] x);
      bus(ad, 1'b0, 8'h00);
      check(rd, x);
   endtask : rdchk
   task wait_req;
      n = 0;
      while (creq.req !== 1'b1 && n < 700) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_req
   task wait_take(input int t0);
      hold <= 1'b0;
      n = 0;
      while (taken == t0 && n < 50) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_take
   task fire(input int k);
      @(posedge clk);
      if (k == SRC_CARD) ev.card <= seed[5:0] | 6'h01;
      if (k == SRC_EP) ev.endpoint <= 1'b1;
      if (k == SRC_EXT0 || k == SRC_EXT1) pins[k - SRC_EXT0] <= 1'b1;
      if (k == SRC_UART0 || k == SRC_UART1) ev.uart[k - SRC_UART0] <= 1'b1;
      if (k == SRC_PRES) ev.presence <= 1'b1;
      @(posedge clk);
      ev <= '0;
      if (k >= SRC_TB0) bus(OFS_TB0 + 8'(4 * (k - SRC_TB0)), 1'b1, 8'h80);
   endtask : fire
   task summarize;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : summarize

   // Main sequence: reset, registers, every source, priority, edges, time bases.
   initial begin
      {cyc, stb, we, full, hold, slow, pins, adr, wdat, ev} = '0;
      {fail_count, checks, cycles, taken, wakes} = '0;
      fsel = 2'h3;
      seed = 32'h922c5d7b;
      rst = 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 10; i++) rdchk(8'(4 * i), 8'h00);
      seed = xs(seed);
      bus(OFS_TB0, 1'b1, seed[7:0]);
      rdchk(OFS_TB0, seed[7:0] & 8'h87);
      bus(OFS_TB0, 1'b1, 8'h00);
      bus(OFS_PSC, 1'b1, seed[15:8]);
      rdchk(OFS_PSC, seed[15:8] & 8'h03);
      bus(OFS_PSC, 1'b1, 8'h00);
      bus(OFS_CTRL0, 1'b1, 8'hFE);
      rdchk(OFS_CTRL0, 8'h7E);
      check(creq.req, 1'b0);
      bus(OFS_CTRL0, 1'b1, 8'h00);
      bus(OFS_CARD_EN, 1'b1, {2'h0, seed[21:16] | 6'h01});
      rdchk(OFS_CTRL0, 8'h02);
      bus(8'h24, 1'b1, 8'hFF);
      rdchk(8'h24, 8'h00);
      bus(OFS_EDGE, 1'b1, 8'h05);
      for (int k = 0; k < NSRC; k++) begin
         a = 8'(SRC_REG[k] * 4);
         e = 8'(1 << EN_BIT[k]);
         seed = xs(seed);
         slow <= seed[0];
         hold <= 1'b1;
         bus(a, 1'b1, e | {7'h0, a == OFS_CTRL0});
         if (a != OFS_CTRL0) bus(OFS_CTRL0, 1'b1, 8'h01);
         w = wakes;
         t = taken;
         fire(k);
         wait_req();
         check(creq.vector, k);
         full <= 1'b1;
         repeat (3) @(posedge clk);
         check(creq.req, 1'b0);
         full <= 1'b0;
         wait_take(t);
         check(wakes != w, 1'b1);
         rdchk(a, e);
         if (a != OFS_CTRL0) rdchk(OFS_CTRL0, 8'h00);
         if (k >= SRC_TB0) bus(OFS_TB0 + 8'(4 * (k - SRC_TB0)), 1'b1, 8'h00);
         bus(a, 1'b1, 8'h00);
         pins <= 2'h0;
      end
      hold <= 1'b1;
      bus(OFS_CTRL1, 1'b1, 8'h02);
      bus(OFS_CTRL0, 1'b1, 8'h05);
      ev.endpoint <= 1'b1;
      ev.uart <= 2'h1;
      @(posedge clk);
      ev <= '0;
      repeat (4) @(posedge clk);
      check(creq.vector, SRC_EP);
      wait_take(taken);
      rdchk(OFS_CTRL1, 8'h22);
      t = taken;
      bus(OFS_CTRL0, 1'b1, 8'h05);
      wait_take(t);
      check(tvec, SRC_UART0);
      bus(OFS_CTRL1, 1'b1, 8'h00);
      for (int c = 0; c < 5; c++) begin
         for (int r = 0; r < 2; r++) begin
            cd = (c < 4) ? c[1:0] : 2'h3;
            fsel <= {1'b1, c < 4};
            pins[0] <= !r;
            bus(OFS_EDGE, 1'b1, {6'h0, cd});
            repeat (4) @(posedge clk);
            bus(OFS_CTRL0, 1'b1, 8'h08);
            pins[0] <= r[0];
            repeat (6) @(posedge clk);
            rdchk(OFS_CTRL0, {1'b0, hit(cd, r[0], c < 4), 6'h08});
            check(creq.req, 1'b0);
         end
      end
      for (int i = 0; i < 5; i++) begin
         bus(OFS_CTRL2, 1'b1, pre[i]);
         bus(OFS_PSC, 1'b1, {6'h0, pt[i]});
         p = period(pt[i], ct[i]);
         w = wakes;
         bus(OFS_TB0, 1'b1, 8'h80 | 8'(ct[i]));
         n = 0;
         while (wakes == w && n < p + 40) begin
            @(posedge clk);
            n++;
         end
         check((pre[i] != 0) ? (n >= p + 40) :
            (n >= p - (4 << pt[i]) && n <= p + (4 << pt[i])), 1'b1);
         bus(OFS_TB0, 1'b1, 8'h00);
      end
      bus(OFS_CTRL2, 1'b1, 8'h00);
      repeat (300) @(posedge clk);
      rdchk(OFS_CTRL2, 8'h00);
      summarize();
   end
endmodule : testbench

bind interrupt_and_time_base_unit irq_unit_chk irq_unit_chk_i (.clk(clk), .rst(rst),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .stack_full(stack_full), .core_ack(core_ack), .core_req(core_req), .wake(wake));
